// File: bench/contactor_model.sv
`timescale 1ns/1ns
module contactor_model #(
    parameter int DLY = 3  // Mechanical travel in clocks
) (
    input wire logic clock,
    input wire logic cmd,
    input wire logic stuck,
    output logic     auxClosed,
    output logic     auxOpen
);
    logic [DLY-1:0] travel = '0;  // Armature position pipeline
    // A stuck contactor keeps its last position, whatever is commanded
    always @(posedge clock) begin
        if (!stuck) travel <= {travel[DLY-2:0], cmd};
    end
    assign auxClosed = travel[DLY-1];
    assign auxOpen   = !travel[DLY-1];
endmodule

// File: bench/transfer_switch_supervisor_bench.sv
`timescale 1ns/1ns
module transfer_switch_supervisor_bench;
    import ts_pkg::*;
    localparam int HR = 3, UC = 2, GC = 1, NR = 0;  // Bit positions in mon
    logic        clock, rstn, hsel, hwrite, hresp, irq, shutdownReq;
    logic        loss, xfer, byp, btn, rem, gStuck;   // Pins and fault knob
    logic        uAuxC, uAuxO, gAuxC, gAuxO;          // Contactor feedback
    logic        hreadyout, utilCloseCmd, genCloseCmd, notReducedPower;
    logic [1:0]  htrans;
    logic [7:0]  freq, volt;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [3:0]  mon;                                 // Watched outputs
    pins_t       pins;
    int          nFail, samplesChecked, seed;
    logic [15:0] spQ[$];                              // Model of the setpoint store
    assign pins = {loss, xfer, byp, uAuxC, uAuxO, gAuxC, gAuxO, btn, rem};
    assign mon  = {hreadyout, utilCloseCmd, genCloseCmd, notReducedPower};
    transfer_switch_supervisor #(.TICK_CYCLES(10)) dut (.clock, .rstn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pins,
        .genFreqPct(freq), .genVoltPct(volt), .utilCloseCmd, .genCloseCmd, .notReducedPower,
        .shutdownReq, .irq);
    contactor_model uCon (.clock, .cmd(utilCloseCmd), .stuck(1'b0), .auxClosed(uAuxC),
        .auxOpen(uAuxO));
    contactor_model gCon (.clock, .cmd(genCloseCmd), .stuck(gStuck), .auxClosed(gAuxC),
        .auxOpen(gAuxO));
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    task automatic endSim;
        if (nFail == 0 && samplesChecked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        samplesChecked++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            nFail++;
        end
    endtask
    // Bounded wait on one watched output; a hang counts as a mismatch
    task automatic waitBit(input int k, input logic v);
        int i;
        i = 0;
        do @(posedge clock); while (mon[k] !== v && ++i < 3000);
        if (mon[k] !== v) begin
            nFail++;
            endSim;
        end
    endtask
    // One single AHB transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        waitBit(HR, 1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        waitBit(HR, 1);
        rdat = hrdata;
    endtask
    initial begin
        {rstn, hsel, hwrite, loss, xfer, byp, btn, rem, gStuck} = '0;
        {htrans, haddr, hwdata} = '0;
        {freq, volt} = {8'h59, 8'h64};  // Frequency one below the ready threshold
        {nFail, samplesChecked, seed} = {32'h0, 32'h0, 32'hABF4};
        repeat (20) @(posedge clock);
        rstn <= 1;
        @(posedge clock);
        bus(0, A_CTRL, 0);
        chk(rdat, 0, "ctrl reset");
        bus(1, 8'hFC, 32'hFFFF_FFFF);
        bus(0, 8'hFC, 0);
        chk(rdat, 0, "unmapped");
        bus(0, A_CMD, 0);
        chk(rdat, 0, "cmd reads zero");
        for (int i = 0; i < NSP; i++) begin
            spQ.push_back(i == SP_RPCT ? 16'h005A : (i == SP_U2GW || i == SP_U2GS ||
                i == SP_G2U) ? 16'h000A : 16'(2 + {$random(seed)} % 4));  // Failures outlast gaps
            bus(1, A_SP0 + 8'(4 * i), 32'(spQ[i]));
        end
        for (int i = 0; i < NSP; i++) begin
            bus(0, A_SP0 + 8'(4 * i), 0);
            chk(rdat, 32'(spQ[i]), "setpoint");
        end
        bus(1, A_IMASK, 32'h3F);
        bus(1, A_CTRL, 32'h5);  // Auto mode with a register transfer request
        waitBit(UC, 1);
        repeat (100) @(posedge clock);
        bus(0, A_STAT, 0);
        chk(rdat, {S_UTIL, 8'h10}, "status idle");
        freq <= 8'h5A + 8'({$random(seed)} % 16);
        loss <= 1;
        bus(0, A_STAT, 0);
        chk(rdat[0], 0, "loss early");
        waitBit(GC, 1);
        repeat (10) @(posedge clock);
        bus(0, A_STAT, 0);
        chk(rdat, {S_GEN, 8'h43}, "status gen");
        chk(irq, 1, "irq raised");
        loss <= 0;
        bus(1, A_ISTAT, 32'h3F);
        waitBit(UC, 1);
        repeat (10) @(posedge clock);
        bus(0, A_STAT, 0);
        chk(rdat, {S_UTIL, 8'h12}, "status back");
        bus(1, A_ISTAT, 32'h3F);
        gStuck <= 1;  // Generator contactor refuses to close
        bus(1, A_CTRL, 32'h7);  // Manual mode with request
        waitBit(UC, 0);
        waitBit(UC, 1);
        bus(0, A_FAIL, 0);
        chk(rdat, 32'h3, "fail flags");
        chk(shutdownReq, 1, "shutdown");
        chk(irq, 1, "irq fail");
        bus(1, A_IMASK, 0);
        repeat (300) @(posedge clock);
        chk({irq, genCloseCmd}, 0, "masked, no retry");
        bus(1, A_CMD, 32'h2);
        repeat (10) @(posedge clock);
        gStuck <= 0;
        bus(0, A_FAIL, 0);
        chk({rdat[30:0], shutdownReq}, 0, "fail cleared");
        waitBit(GC, 1);
        bus(1, A_CMD, 32'h4);
        repeat (3) @(posedge clock);
        chk(mon[2:0], 0, "reduced power");
        {xfer, byp} <= 2'h3;
        repeat (50) @(posedge clock);
        chk(notReducedPower, 0, "no wake");
        {xfer, byp, btn} <= 3'h1;
        waitBit(NR, 1);
        btn <= 0;
        endSim;
    end
endmodule

// File: bench/transfer_switch_supervisor_sva.sv
`timescale 1ns/1ns
module transfer_switch_supervisor_chk
    import ts_pkg::*;
(
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire pins_t       pins,
    input wire logic        utilCloseCmd,
    input wire logic        genCloseCmd,
    input wire logic        notReducedPower,
    input wire logic        shutdownReq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic [5:0] wakeHist;  // Recent wake inputs, covers the pin synchroniser delay
    wire rstWr = hwdata[K_RST] && haddr[7:0] == A_CMD;  // Failure reset write in flight
    // Shift register of wake sources
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) wakeHist <= '0;
        else wakeHist <= {wakeHist[4:0], pins.button | pins.remoteInit};
    end
    sequence rdCmd;
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == A_CMD;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    a_cmd_reads0: assert property (rdCmd |=> hrdata == 32'h0) else $error("command reads");
    a_sleep_trips: assert property (!notReducedPower [*2] |-> !utilCloseCmd && !genCloseCmd)
        else $error("command high in reduced power");
    a_wake_only: assert property ($rose(notReducedPower) && $past(rstn, 2) |-> |wakeHist)
        else $error("woke without button or remote");
    a_not_both: assert property (!(utilCloseCmd && genCloseCmd)) else $error("both closed");
    a_gen_gap: assert property ($rose(genCloseCmd) |-> !$past(utilCloseCmd, 8))
        else $error("gen closed too soon");
    a_util_gap: assert property ($rose(utilCloseCmd) |-> !$past(genCloseCmd, 8))
        else $error("util closed too soon");
    a_shut_hold: assert property ($fell(shutdownReq) |-> !notReducedPower ||
        $past(rstWr, 2)) else $error("shutdown dropped without reset");
endmodule
bind transfer_switch_supervisor transfer_switch_supervisor_chk chk (.clock, .rstn, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .pins,
    .utilCloseCmd, .genCloseCmd, .notReducedPower, .shutdownReq);

// File: hw/transfer_switch_supervisor.sv
`timescale 1ns/1ns
module transfer_switch_supervisor #(
    parameter int TICK_CYCLES = ts_pkg::TICK_CYC     // Clocks per 1 ms timer tick
) (
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic [31:0]             hrdata,
    output logic                    hresp,
    input  wire ts_pkg::pins_t      pins,
    input  wire logic [7:0]         genFreqPct,
    input  wire logic [7:0]         genVoltPct,
    output logic                    utilCloseCmd,
    output logic                    genCloseCmd,
    output logic                    notReducedPower,
    output logic                    shutdownReq,
    output logic                    irq
);
    import ts_pkg::*;

    pins_t               pinsS1;          // First synchroniser stage, read only by the second
    pins_t               pinsS2;          // Synchronised pins
    logic [31:0]         tickCnt;         // Prescaler
    logic                tick;            // One-cycle 1 ms strobe
    logic [TW-1:0]       sp [NSP];        // Setpoints
    logic [2:0]          ctrlReg;         // Enable, manual mode, transfer command
    logic [NEV-1:0]      istatReg;        // Sticky events
    logic [NEV-1:0]      imaskReg;        // Interrupt mask
    logic [2:0]          failReg;         // Latched failures: u2g warn, u2g shutdown, g2u
    logic                bypassCmd;       // Register bypass pulse
    logic                rstFailCmd;      // Failure reset pulse
    logic                sleepCmd;        // Enter reduced power pulse
    logic                wrPend;          // Write data phase pending
    logic [7:0]          wrAddr;          // Captured write address
    logic [31:0]         rdMux;           // Read data for the address phase
    logic                utilFault;       // Debounced loss of utility
    logic [TW-1:0]       noteCnt;         // Debounce timer
    logic                genReady;        // Generator qualified
    logic [TW-1:0]       readyCnt;        // Readiness timer
    logic [TW-1:0]       unpwCnt;         // Time both contactors open
    logic [TW-1:0]       stateCnt;        // Time in current state
    logic [TW-1:0]       cmdCnt;          // Time utility close command has stood
    logic                reducedReg;      // Reduced power mode
    logic                attemptReg;      // Current close is a real transfer attempt
    logic                attemptNext;
    state_t              stateReg;
    state_t              stateNext;
    logic [1:0]          utilPos;         // Utility contactor position code
    logic [1:0]          genPos;          // Generator contactor position code
    logic                xferReq;         // Merged transfer-to-generator request
    logic                bypassReq;       // Merged bypass request
    logic                wantGen;         // Generator power demanded
    logic                unpwOk;          // Bus unpowered long enough
    logic [TW-1:0]       stabDelay;       // Selected stability delay
    logic                u2gWarnHit;
    logic                u2gShutHit;
    logic [NEV-1:0]      evNow;           // Events raised this cycle
    logic                utilCmdNext;
    logic                genCmdNext;

    // Two flops on every pin before any logic sees it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pinsS1 <= '0;
            pinsS2 <= '0;
        end else begin
            pinsS1 <= pins;
            pinsS2 <= pinsS1;
        end
    end

    // Millisecond tick; long timers count ticks to keep them narrow
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tickCnt <= '0;
            tick    <= 1'b0;
        end else if (tickCnt >= 32'(TICK_CYCLES - 1)) begin
            tickCnt <= '0;
            tick    <= 1'b1;
        end else begin
            tickCnt <= tickCnt + 32'h1;
            tick    <= 1'b0;
        end
    end

    // Position codes from the two auxiliary contacts
    always_comb begin
        utilPos = {pinsS2.utilAuxClosed, pinsS2.utilAuxOpen} == 2'b10 ? POS_CLOSED :
                  {pinsS2.utilAuxClosed, pinsS2.utilAuxOpen} == 2'b01 ? POS_OPEN :
                  {pinsS2.utilAuxClosed, pinsS2.utilAuxOpen} == 2'b11 ? POS_BOTH : POS_NONE;
        genPos  = {pinsS2.genAuxClosed, pinsS2.genAuxOpen} == 2'b10 ? POS_CLOSED :
                  {pinsS2.genAuxClosed, pinsS2.genAuxOpen} == 2'b01 ? POS_OPEN :
                  {pinsS2.genAuxClosed, pinsS2.genAuxOpen} == 2'b11 ? POS_BOTH : POS_NONE;
    end

    // Request merging; a pin that asks wins over the register
    always_comb begin
        xferReq   = pinsS2.xferGen | ctrlReg[C_XFER];
        bypassReq = pinsS2.bypass | bypassCmd;
        wantGen   = utilFault | (ctrlReg[C_MAN] & xferReq);
        unpwOk    = unpwCnt >= sp[SP_UNPW];
        stabDelay = (genPos == POS_CLOSED) ? sp[SP_STAB] : sp[SP_FAST];
        u2gWarnHit = attemptReg && sp[SP_U2GW] != '0 && stateCnt >= sp[SP_U2GW];
        u2gShutHit = attemptReg && sp[SP_U2GS] != '0 && stateCnt >= sp[SP_U2GS];
    end

    // Loss of utility debounce, same delay in both directions
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            utilFault <= 1'b0;
            noteCnt   <= '0;
        end else if (pinsS2.lossUtil == utilFault) begin
            noteCnt <= '0;
        end else if (noteCnt >= sp[SP_NOTE]) begin
            utilFault <= pinsS2.lossUtil;
            noteCnt   <= '0;
        end else if (tick) begin
            noteCnt <= noteCnt + 1'b1;
        end
    end

    // Generator readiness: both readings at or above threshold for the delay
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            genReady <= 1'b0;
            readyCnt <= '0;
        end else if (genFreqPct < sp[SP_RPCT][7:0] || genVoltPct < sp[SP_RPCT][7:0]) begin
            genReady <= 1'b0;
            readyCnt <= '0;
        end else if (readyCnt >= sp[SP_RDLY]) begin
            genReady <= 1'b1;
        end else if (tick) begin
            readyCnt <= readyCnt + 1'b1;
        end
    end

    // Unpowered-bus, state and close-command timers; all saturate
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            unpwCnt  <= '0;
            stateCnt <= '0;
            cmdCnt   <= '0;
        end else begin
            if (utilPos != POS_OPEN || genPos != POS_OPEN || utilCloseCmd || genCloseCmd) begin
                unpwCnt <= '0;
            end else if (tick && unpwCnt != '1) begin
                unpwCnt <= unpwCnt + 1'b1;
            end
            if (stateNext != stateReg) begin
                stateCnt <= '0;
            end else if (tick && stateCnt != '1) begin
                stateCnt <= stateCnt + 1'b1;
            end
            if (!utilCloseCmd || stateReg != S_CLOSE_U) begin
                cmdCnt <= '0;
            end else if (tick && cmdCnt != '1) begin
                cmdCnt <= cmdCnt + 1'b1;
            end
        end
    end

    // Transfer sequencer
    always_comb begin
        stateNext   = stateReg;
        attemptNext = attemptReg;
        evNow       = '0;
        case (stateReg)
            S_OFF: begin
                // Pick up whatever the contactors show when enabled
                if (utilPos == POS_CLOSED) begin
                    stateNext = S_UTIL;
                end else if (genPos == POS_CLOSED) begin
                    stateNext = S_GEN;
                end else begin
                    stateNext   = S_CLOSE_U;
                    attemptNext = 1'b0;
                end
            end
            S_UTIL: begin
                if (wantGen && genReady && failReg[1:0] == 2'b00) begin
                    stateNext = S_OPEN_U;
                end
            end
            S_OPEN_U: begin
                if (utilPos == POS_OPEN) begin
                    stateNext   = S_CLOSE_G;
                    attemptNext = 1'b1;
                end else if (stateCnt >= sp[SP_OPEN]) begin
                    stateNext       = S_UTIL;
                    evNow[E_OPTO]   = 1'b1;
                end
            end
            S_CLOSE_G: begin
                if (genPos == POS_CLOSED) begin
                    stateNext = S_GEN;
                end else if (u2gWarnHit || u2gShutHit) begin
                    stateNext     = S_CLOSE_U;
                    attemptNext   = 1'b0;
                    evNow[E_U2GW] = u2gWarnHit;
                    evNow[E_U2GS] = u2gShutHit;
                end
            end
            S_GEN: begin
                if (!wantGen && !failReg[2]) begin
                    stateNext = S_STAB;
                end
            end
            S_STAB: begin
                // Bypass only acts here, so it cannot reach a later delay
                if (wantGen) begin
                    stateNext = S_GEN;
                end else if (bypassReq || stateCnt >= stabDelay) begin
                    stateNext = S_OPEN_G;
                end
            end
            S_OPEN_G: begin
                if (genPos == POS_OPEN) begin
                    stateNext   = S_CLOSE_U;
                    attemptNext = 1'b1;
                end
            end
            S_CLOSE_U: begin
                if (utilPos == POS_CLOSED) begin
                    stateNext = S_UTIL;
                end else if (attemptReg && stateCnt >= sp[SP_G2U]) begin
                    stateNext    = S_CLOSE_G;
                    attemptNext  = 1'b0;
                    evNow[E_G2U] = 1'b1;
                end else if (cmdCnt >= sp[SP_CLOS] && utilCloseCmd) begin
                    stateNext     = S_CLOSE_G;
                    attemptNext   = 1'b0;
                    evNow[E_CLTO] = 1'b1;
                end
            end
            default: begin
                stateNext = S_OFF;
            end
        endcase
        // Disabled or asleep: park the sequencer
        if (!ctrlReg[C_EN] || reducedReg) begin
            stateNext   = S_OFF;
            attemptNext = 1'b0;
            evNow[E_OPTO:E_U2GW] = '0;
        end
        evNow[E_UFLT] = (noteCnt >= sp[SP_NOTE]) && (pinsS2.lossUtil != utilFault);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stateReg   <= S_OFF;
            attemptReg <= 1'b0;
        end else begin
            stateReg   <= stateNext;
            attemptReg <= attemptNext;
        end
    end

    // Contactor commands; a close waits for the unpowered bus time
    always_comb begin
        utilCmdNext = 1'b0;
        genCmdNext  = 1'b0;
        case (stateNext)
            S_UTIL:    utilCmdNext = 1'b1;
            S_CLOSE_U: utilCmdNext = utilCloseCmd | unpwOk;
            S_GEN:     genCmdNext  = 1'b1;
            S_STAB:    genCmdNext  = 1'b1;
            S_CLOSE_G: genCmdNext  = genCloseCmd | unpwOk;
            default: begin
                utilCmdNext = 1'b0;
                genCmdNext  = 1'b0;
            end
        endcase
    end

    // Reduced power; only a button or remote initiate wakes the block
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reducedReg <= 1'b0;
        end else if (pinsS2.button || pinsS2.remoteInit) begin
            reducedReg <= 1'b0;
        end else if (sleepCmd) begin
            reducedReg <= 1'b1;
        end
    end

    // Outputs, all but irq blanked in reduced power
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            utilCloseCmd    <= 1'b0;
            genCloseCmd     <= 1'b0;
            notReducedPower <= 1'b0;
            shutdownReq     <= 1'b0;
            irq             <= 1'b0;
        end else begin
            utilCloseCmd    <= utilCmdNext & ~reducedReg;
            genCloseCmd     <= genCmdNext & ~reducedReg;
            notReducedPower <= ~reducedReg;
            shutdownReq     <= failReg[1] & ~reducedReg;
            irq             <= |(istatReg & imaskReg);
        end
    end

    // Failure latches: only the reset pulse clears, a new event wins
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            failReg <= '0;
        end else begin
            failReg <= (rstFailCmd ? 3'h0 : failReg) | evNow[E_G2U:E_U2GW];
        end
    end

    // Sticky interrupt status, write one to clear; set wins
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            istatReg <= '0;
        end else if (wrPend && wrAddr == A_ISTAT) begin
            istatReg <= (istatReg & ~hwdata[NEV-1:0]) | evNow;
        end else begin
            istatReg <= istatReg | evNow;
        end
    end

    // Bus address phase: zero wait states, read data ready at the next edge
    always_comb begin
        rdMux = 32'h0;
        case (haddr[7:0])
            A_CTRL:  rdMux = {29'h0, ctrlReg};
            A_STAT:  rdMux = {16'h0, stateReg, genPos, utilPos, reducedReg,
                              stateReg == S_STAB, genReady, utilFault};
            A_ISTAT: rdMux = {{(32-NEV){1'b0}}, istatReg};
            A_IMASK: rdMux = {{(32-NEV){1'b0}}, imaskReg};
            A_FAIL:  rdMux = {29'h0, failReg};
            default: begin
                if (haddr[7:0] >= A_SP0 && haddr[7:0] < A_SP0 + 8'(4 * NSP)) begin
                    rdMux = {16'h0, sp[4'((haddr[7:0] - A_SP0) >> 2)]};
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wrPend    <= 1'b0;
            wrAddr    <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend    <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
            wrAddr    <= haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata <= rdMux;
            end
        end
    end

    // Register writes in the data phase; command bits last one cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrlReg    <= CTRL_RST;
            imaskReg   <= '0;
            bypassCmd  <= 1'b0;
            rstFailCmd <= 1'b0;
            sleepCmd   <= 1'b0;
            for (int i = 0; i < NSP; i++) begin
                sp[i] <= SP_RST[i];
            end
        end else begin
            bypassCmd  <= wrPend && wrAddr == A_CMD && hwdata[K_BYP];
            rstFailCmd <= wrPend && wrAddr == A_CMD && hwdata[K_RST];
            sleepCmd   <= wrPend && wrAddr == A_CMD && hwdata[K_SLEEP];
            if (wrPend && wrAddr == A_CTRL) begin
                ctrlReg <= hwdata[2:0];
            end
            if (wrPend && wrAddr == A_IMASK) begin
                imaskReg <= hwdata[NEV-1:0];
            end
            for (int i = 0; i < NSP; i++) begin
                if (wrPend && wrAddr == A_SP0 + 8'(4 * i)) begin
                    sp[i] <= hwdata[TW-1:0];
                end
            end
        end
    end

endmodule

// File: inc/ts_pkg.sv
// Function
// - Fast-return delay when generator not feeding load
// - Utility-to-generator failure timer, abandon to utility
// - Latched utility-to-generator failure blocks generator transfer
// - Shutdown failure event also commands red-lamp shutdown
// - Generator-to-utility failure timer, return to generator
// - Latched generator-to-utility failure blocks utility transfer
// - Generator ready after frequency, voltage held over delay
// - Auto mode on utility loss; manual adds commands
// - Utility close timeout returns to generator power
// - Utility open timeout returns to utility power
// - Closing requires bus unpowered for minimum time
// - Reduced power mode trips every output except irq
// - Only button or remote initiate ends reduced power
// - Not-in-reduced-power output high outside the mode
// - Contactor position code: open, closed, unknown
// - Bypass is momentary, expires only running stability timers
// - Hardwired inputs override register commands
// - Utility loss input debounced both directions
package ts_pkg;

    localparam int TW = 16;                        // Width of every tick timer and setpoint

    // Register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;        // Enable, mode, transfer command
    localparam logic [7:0] A_CMD   = 8'h04;        // Write-only pulses
    localparam logic [7:0] A_STAT  = 8'h08;        // Live status
    localparam logic [7:0] A_ISTAT = 8'h0C;        // Sticky events, write one to clear
    localparam logic [7:0] A_IMASK = 8'h10;        // Interrupt mask
    localparam logic [7:0] A_FAIL  = 8'h14;        // Latched failure flags
    localparam logic [7:0] A_SP0   = 8'h20;        // First setpoint word

    // Setpoint indices, all in 1 ms ticks except the percentage
    localparam int NSP     = 11;
    localparam int SP_FAST = 0;                    // Fast-return stability delay
    localparam int SP_STAB = 1;                    // Normal stability delay
    localparam int SP_U2GW = 2;                    // Utility to generator failure warning
    localparam int SP_U2GS = 3;                    // Utility to generator failure shutdown
    localparam int SP_G2U  = 4;                    // Generator to utility failure
    localparam int SP_RDLY = 5;                    // Generator ready delay
    localparam int SP_RPCT = 6;                    // Generator ready percentage
    localparam int SP_CLOS = 7;                    // Utility maximum closing time
    localparam int SP_OPEN = 8;                    // Utility maximum opening time
    localparam int SP_UNPW = 9;                    // Minimum unpowered load time
    localparam int SP_NOTE = 10;                   // Loss of utility notification delay
    localparam logic [TW-1:0] SP_RST [NSP] = '{16'h0BB8, 16'h7530, 16'h2710, 16'h0000,
                                               16'h2710, 16'h0BB8, 16'h005A, 16'h03E8,
                                               16'h03E8, 16'h01F4, 16'h0BB8};

    // Control bits
    localparam int C_EN   = 0;
    localparam int C_MAN  = 1;
    localparam int C_XFER = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // Command pulse bits
    localparam int K_BYP   = 0;
    localparam int K_RST   = 1;
    localparam int K_SLEEP = 2;

    // Event bits
    localparam int NEV    = 6;
    localparam int E_U2GW = 0;
    localparam int E_U2GS = 1;
    localparam int E_G2U  = 2;
    localparam int E_CLTO = 3;
    localparam int E_OPTO = 4;
    localparam int E_UFLT = 5;

    // Contactor position codes
    localparam logic [1:0] POS_OPEN   = 2'h0;
    localparam logic [1:0] POS_CLOSED = 2'h1;
    localparam logic [1:0] POS_NONE   = 2'h2;
    localparam logic [1:0] POS_BOTH   = 2'h3;

    // Time base
    localparam int CLK_NS   = 10;
    localparam int TICK_NS  = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;

    typedef enum logic [7:0] {
        S_OFF     = 8'h01,
        S_UTIL    = 8'h02,
        S_OPEN_U  = 8'h04,
        S_CLOSE_G = 8'h08,
        S_GEN     = 8'h10,
        S_STAB    = 8'h20,
        S_OPEN_G  = 8'h40,
        S_CLOSE_U = 8'h80
    } state_t;

    typedef struct packed {
        logic lossUtil;
        logic xferGen;
        logic bypass;
        logic utilAuxClosed;
        logic utilAuxOpen;
        logic genAuxClosed;
        logic genAuxOpen;
        logic button;
        logic remoteInit;
    } pins_t;

endpackage
